// ### bench/pgs_props.sv
// Checker: timing properties on the gating link
`timescale 1ns/1ps
`default_nettype none
module pgs_props #(
  parameter int FLO = 20,
  parameter int FHI = 40,
  parameter int CEND = 10,
  parameter int THI = 80,
  parameter int CTOL = 80
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link signals
  input wire logic gating_request,
  input wire logic timer_hold,
  input wire logic process_gating,
  input wire logic field_interrupted
);
  logic pg;
  logic fi;
  logic rq;
  int clr_cnt;
  int idl_cnt;
  int wt_cnt;
  assign pg = process_gating;
  assign fi = field_interrupted;
  assign rq = gating_request;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clr_cnt <= 0;
      idl_cnt <= 0;
      wt_cnt <= 0;
    end else begin
      clr_cnt <= (pg && !fi) ? clr_cnt + 1 : 0;
      idl_cnt <= (pg && !fi && !rq) ? idl_cnt + 1 : 0;
      wt_cnt <= (rq && !pg) ? wt_cnt + 1 : 0;
    end
  end
  //////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Slack covers the pin synchroniser and output lag
  property p_auto_end;
    pg |-> clr_cnt <= FHI + 3;
  endproperty
  a_auto_end: assert property (p_auto_end)
    else $error("gating outlived filter time");
  property p_gap_keep;
    pg && rq && !fi && clr_cnt < FLO - 3 |=> pg;
  endproperty
  a_gap_keep: assert property (p_gap_keep)
    else $error("gating dropped on short gap");
  property p_ctl_end;
    pg |-> idl_cnt <= CEND + 7;
  endproperty
  a_ctl_end: assert property (p_ctl_end)
    else $error("controlled end too late");
  property p_ctl_min;
    pg && !rq && idl_cnt < CEND - 1 && clr_cnt < FLO - 3 |=> pg;
  endproperty
  a_ctl_min: assert property (p_ctl_min)
    else $error("controlled end too early");
  property p_start_req;
    $rose(pg) |-> rq && wt_cnt <= THI + 8;
  endproperty
  a_start_req: assert property (p_start_req)
    else $error("gating began outside tolerance");
  property p_start_fld;
    $rose(pg) |-> fi;
  endproperty
  a_start_fld: assert property (p_start_fld)
    else $error("gating began on a clear field");
  property p_ctl_tol;
    rq |-> wt_cnt <= CTOL + 3;
  endproperty
  a_ctl_tol: assert property (p_ctl_tol)
    else $error("request held past tolerance");
  property p_hold_anti;
    $rose(rq) |-> !timer_hold;
  endproperty
  a_hold_anti: assert property (p_hold_anti)
    else $error("hold not antivalent to request");
  c_gate: cover property ($rose(pg));
  c_auto: cover property ($fell(pg) && rq);
  c_ctl: cover property ($fell(pg) && !rq);
  c_tol: cover property (wt_cnt == THI);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Testbench: both link ends, mode table and corner cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [2:0] br;
    logic [6:0] seg;
    int filt;
    logic hu;
  } pgs_row_s;
  localparam int F4 = 32'h14;
  localparam int F5 = 32'h1E;
  localparam int F16 = 32'h28;
  localparam int T4 = 32'h3C;
  localparam int TS = 32'h50;
  localparam int CE = 32'hA;
  localparam int TM = 32'h7D0;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] beams = 16'h0000;
  logic [2:0] bridge = pgs_pkg::BRIDGE_M1;
  logic rst_p = 1'b0;
  logic go = 1'b0;
  logic near = 1'b0;
  logic hu = 1'b0;
  logic e_end = 1'b0;
  logic ext = 1'b0;
  logic blk = 1'b0;
  logic teach = 1'b0;
  logic past = 1'b0;
  logic safety_on;
  logic mode_fault;
  logic late_fault;
  logic [6:0] seg_n;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  logic [2:0] bad [3] = '{3'h0, 3'h5, 3'h7};
  pgs_row_s rows [4] = '{
    '{pgs_pkg::BRIDGE_M1, pgs_pkg::SEG_1, F16, 1'b1},
    '{pgs_pkg::BRIDGE_M4, pgs_pkg::SEG_4, F4, 1'b0},
    '{pgs_pkg::BRIDGE_M5, pgs_pkg::SEG_5, F5, 1'b0},
    '{pgs_pkg::BRIDGE_M6, pgs_pkg::SEG_6, F16, 1'b1}};
  pgs_link_if lnk ();
  always #2.5 clk_sys = ~clk_sys;
  // Counts shortened so every sequence fits in a few thousand cycles
  pgs_device #(
    .FILT_M4(48'(F4)), .FILT_M5(48'(F5)), .FILT_M16(48'(F16)),
    .TOL_M4(48'(T4)), .TOL_STD(48'(TS)), .CTL_END(48'(CE)),
    .PAIR_WIN(48'h10), .TMO(48'(TM)), .TMO_EXT(48'hFA0)
  ) i_pgs_device (
    .clk_sys(clk_sys), .resetn(resetn), .link(lnk),
    .beams_blocked(beams), .mode_bridge(bridge),
    .timeout_ext_en(ext), .blank_en(blk), .teach_pulse(teach),
    .restart_pulse(rst_p), .safety_on(safety_on),
    .mode_fault(mode_fault), .seg_n(seg_n)
  );
  pgs_control #(.TOL(48'(TS)), .STRETCH(48'h32)) i_pgs_control (
    .clk_sys(clk_sys), .resetn(resetn), .link(lnk), .seq_go(go),
    .near_sensor(near), .past_pos(past), .use_hold(hu),
    .early_end(e_end), .late_fault(late_fault)
  );
  pgs_props #(
    .FLO(F4), .FHI(F16), .CEND(CE), .THI(TS), .CTOL(TS)
  ) i_pgs_props (
    .clk_sys(clk_sys), .resetn(resetn),
    .gating_request(lnk.gating_request), .timer_hold(lnk.timer_hold),
    .process_gating(lnk.process_gating),
    .field_interrupted(lnk.field_interrupted)
  );
  //////////////////////////////
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_rng(input int g, input int lo, input int hi);
    total_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Counts cycles in n; a hang ends the run
  task automatic wait_on(input bit lf, input logic lvl);
    n = 0;
    while ((lf ? late_fault : lnk.process_gating) !== lvl) begin
      cyc(1);
      n++;
      if (n > 400) begin
        miscompares++;
        wrap_up();
      end
    end
  endtask
  task automatic restart();
    rst_p = 1'b1;
    cyc(1);
    rst_p = 1'b0;
    cyc(2);
  endtask
  task automatic set_mode(input logic [2:0] b, input logic h);
    bridge = b;
    hu = h;
    cyc(8);
    restart();
  endtask
  task automatic kick();
    // Stretched sensor must already stand when the step asks
    near = 1'b1;
    cyc(1);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic start_gate();
    kick();
    cyc(8);
    beams = 16'h0010;
    wait_on(0, 1'b1);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  //////////////////////////////
  initial begin
    cyc(3);
    cmp(seg_n, pgs_pkg::SEG_RST);
    cmp(safety_on, 1'b0);
    cyc(3);
    resetn = 1'b1;
    cyc(8);
    cmp(safety_on, 1'b0);
    done("reset");
    foreach (rows[i]) begin
      set_mode(rows[i].br, rows[i].hu);
      cmp(seg_n, rows[i].seg);
      cmp(mode_fault, 1'b0);
      cmp(safety_on, 1'b1);
      start_gate();
      cmp(safety_on, 1'b1);
      beams = 16'h0000;
      wait_on(0, 1'b0);
      cmp_rng(n, rows[i].filt, rows[i].filt + 3);
      cyc(20);
      done("mode row");
    end
    // Gap just under the filter must not end gating
    set_mode(pgs_pkg::BRIDGE_M4, 1'b0);
    start_gate();
    beams = 16'h0000;
    cyc(F4 - 6);
    beams = 16'h0010;
    cyc(4);
    cmp(lnk.process_gating, 1'b1);
    beams = 16'h0000;
    wait_on(0, 1'b0);
    cmp_rng(n, F4, F4 + 3);
    cyc(20);
    done("gap");
    set_mode(pgs_pkg::BRIDGE_M6, 1'b1);
    start_gate();
    beams = 16'h0000;
    cyc(3);
    e_end = 1'b1;
    cyc(1);
    e_end = 1'b0;
    wait_on(0, 1'b0);
    cmp_rng(n, CE, CE + 8);
    cyc(20);
    done("controlled end");
    start_gate();
    beams = 16'h8010;
    cyc(3);
    cmp(safety_on, 1'b0);
    beams = 16'h0000;
    wait_on(0, 1'b0);
    cyc(20);
    restart();
    cmp(safety_on, 1'b1);
    done("top beams");
    // Break lands after device expiry but before the control gives up
    set_mode(pgs_pkg::BRIDGE_M4, 1'b0);
    kick();
    cyc(T4 + 12);
    beams = 16'h0010;
    cyc(4);
    cmp(lnk.process_gating, 1'b0);
    cmp(safety_on, 1'b0);
    wait_on(1, 1'b1);
    cmp_rng(T4 + 17 + n, TS, TS + 4);
    beams = 16'h0000;
    cyc(10);
    done("tolerance");
    // Timeout with a blocked field, then extended and ended by position
    set_mode(pgs_pkg::BRIDGE_M5, 1'b0);
    start_gate();
    cyc(TM - 10);
    cmp(lnk.process_gating, 1'b1);
    wait_on(0, 1'b0);
    cmp_rng(n, 10, 13);
    cyc(2);
    cmp(safety_on, 1'b0);
    beams = 16'h0000;
    ext = 1'b1;
    cyc(8);
    restart();
    start_gate();
    cyc(TM + 10);
    cmp(lnk.process_gating, 1'b1);
    beams = 16'h0000;
    past = 1'b1;
    wait_on(0, 1'b0);
    cmp_rng(n, CE, CE + 8);
    past = 1'b0;
    ext = 1'b0;
    cyc(20);
    done("timeout");
    // Taught beam and its neighbours are ignored
    beams = 16'h0010;
    blk = 1'b1;
    teach = 1'b1;
    cyc(1);
    teach = 1'b0;
    beams = 16'h0020;
    cyc(2);
    restart();
    cmp(safety_on, 1'b1);
    cmp(lnk.field_interrupted, 1'b0);
    beams = 16'h0100;
    cyc(3);
    cmp(safety_on, 1'b0);
    cmp(lnk.field_interrupted, 1'b1);
    beams = 16'h0000;
    blk = 1'b0;
    cyc(4);
    done("blanking");
    foreach (bad[i]) begin
      bridge = bad[i];
      cyc(8);
      cmp(mode_fault, 1'b1);
      cmp(seg_n, pgs_pkg::SEG_ERR);
      restart();
      cmp(safety_on, 1'b0);
    end
    done("bad mode");
    wrap_up();
  end
endmodule
`default_nettype wire

// ### design/pgs_control.sv
// Module: machine control end that drives the gating request
`timescale 1ns/1ps
`default_nettype none
module pgs_control #(
  parameter pgs_pkg::pgs_cnt_t TOL = pgs_pkg::TOL_STD_CYC,
  parameter pgs_pkg::pgs_cnt_t STRETCH = pgs_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link to receiver
  pgs_link_if.control link,
  // Process side
  input wire logic seq_go,
  input wire logic near_sensor,
  input wire logic past_pos,
  input wire logic use_hold,
  input wire logic early_end,
  output logic late_fault
);
  pgs_pkg::pgs_cstate_e st_reg, st_next;
  pgs_pkg::pgs_cnt_t str_reg, str_next;
  pgs_pkg::pgs_cnt_t tmr_reg, tmr_next;
  logic seen_reg, seen_next;
  logic req_reg, req_next;
  logic hold_reg, hold_next;
  logic late_reg, late_next;
  logic near_ok;

  always_comb begin
    // Sensor only qualifies the start after stretching
    str_next = near_sensor ? STRETCH
      : ((str_reg == '0) ? str_reg : str_reg - 48'h1);
    near_ok = (str_reg != '0);
    st_next = st_reg;
    tmr_next = '0;
    seen_next = seen_reg;
    req_next = req_reg;
    hold_next = hold_reg;
    late_next = 1'b0;
    if (st_reg == pgs_pkg::PGC_IDLE) begin
      hold_next = use_hold;
      req_next = 1'b0;
      seen_next = 1'b0;
      // Start needs a process step, never a lone button
      if (seq_go && near_ok) begin
        st_next = pgs_pkg::PGC_REQ;
        req_next = 1'b1;
        hold_next = 1'b0;
      end
    end else begin
      tmr_next = tmr_reg + 48'h1;
      if (link.process_gating) seen_next = 1'b1;
      if (!seen_reg && !link.process_gating && tmr_reg >= TOL) begin
        late_next = 1'b1;
        st_next = pgs_pkg::PGC_IDLE;
      end else if (past_pos) begin
        st_next = pgs_pkg::PGC_IDLE;
      end else if (early_end && !link.field_interrupted) begin
        st_next = pgs_pkg::PGC_IDLE;
      end else if (seen_reg && !link.process_gating) begin
        st_next = pgs_pkg::PGC_IDLE;
      end
      if (st_next == pgs_pkg::PGC_IDLE) begin
        req_next = 1'b0;
        hold_next = use_hold;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= pgs_pkg::PGC_IDLE;
      str_reg <= '0;
      tmr_reg <= '0;
      seen_reg <= 1'b0;
      req_reg <= 1'b0;
      hold_reg <= 1'b0;
      late_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      str_reg <= str_next;
      tmr_reg <= tmr_next;
      seen_reg <= seen_next;
      req_reg <= req_next;
      hold_reg <= hold_next;
      late_reg <= late_next;
    end
  end

  assign link.gating_request = req_reg;
  assign link.timer_hold = hold_reg;
  assign late_fault = late_reg;
endmodule
`default_nettype wire

// ### design/pgs_device.sv
// Module: light curtain receiver end of the gating sequencer
`timescale 1ns/1ps
`default_nettype none
module pgs_device #(
  parameter int N_BEAMS = 16,
  parameter pgs_pkg::pgs_cnt_t FILT_M4 = pgs_pkg::FILT_M4_CYC,
  parameter pgs_pkg::pgs_cnt_t FILT_M5 = pgs_pkg::FILT_M5_CYC,
  parameter pgs_pkg::pgs_cnt_t FILT_M16 = pgs_pkg::FILT_M16_CYC,
  parameter pgs_pkg::pgs_cnt_t TOL_M4 = pgs_pkg::TOL_M4_CYC,
  parameter pgs_pkg::pgs_cnt_t TOL_STD = pgs_pkg::TOL_STD_CYC,
  parameter pgs_pkg::pgs_cnt_t CTL_END = pgs_pkg::CTL_END_CYC,
  parameter pgs_pkg::pgs_cnt_t PAIR_WIN = pgs_pkg::PAIR_WIN_CYC,
  parameter pgs_pkg::pgs_cnt_t TMO = pgs_pkg::TMO_CYC,
  parameter pgs_pkg::pgs_cnt_t TMO_EXT = pgs_pkg::TMO_EXT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link to machine control
  pgs_link_if.device link,
  // Optics and wiring
  input wire logic [N_BEAMS-1:0] beams_blocked,
  input wire logic [2:0] mode_bridge,
  // Options
  input wire logic timeout_ext_en,
  input wire logic blank_en,
  input wire logic teach_pulse,
  input wire logic restart_pulse,
  // Outputs
  output logic safety_on,
  output logic mode_fault,
  output logic [6:0] seg_n
);
  localparam int TB = pgs_pkg::TOP_BEAMS;

  //////////////////////////////////////////////////////////////////////////
  // Pin inputs

  logic [4:0] pins_clean;
  logic req;
  logic hold;
  logic [2:0] bridge;

  pgs_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in({mode_bridge, link.gating_request, link.timer_hold}),
    .level_out(pins_clean)
  );

  assign bridge = pins_clean[4:2];
  assign req = pins_clean[1];
  assign hold = pins_clean[0];

  //////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic m1, m4, m5, m6, bad_mode;
  logic pair_mode;
  pgs_pkg::pgs_cnt_t filt_lim, tol_lim, tmo_lim;
  logic [6:0] seg_next;

  always_comb begin
    m1 = (bridge == pgs_pkg::BRIDGE_M1);
    m4 = (bridge == pgs_pkg::BRIDGE_M4);
    m5 = (bridge == pgs_pkg::BRIDGE_M5);
    m6 = (bridge == pgs_pkg::BRIDGE_M6);
    bad_mode = !(m1 || m4 || m5 || m6);
    pair_mode = m1 || m6;
    filt_lim = m4 ? FILT_M4 : (m5 ? FILT_M5 : FILT_M16);
    tol_lim = m4 ? TOL_M4 : TOL_STD;
    tmo_lim = timeout_ext_en ? TMO_EXT : TMO;
    case (1'b1)
      m1: seg_next = pgs_pkg::SEG_1;
      m4: seg_next = pgs_pkg::SEG_4;
      m5: seg_next = pgs_pkg::SEG_5;
      m6: seg_next = pgs_pkg::SEG_6;
      default: seg_next = pgs_pkg::SEG_ERR;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Beam evaluation with taught blanking

  logic [N_BEAMS-1:0] blank_reg, blank_next;
  logic [N_BEAMS-1:0] ignore, live;
  logic field_int, top_hit;

  genvar b;
  generate
    for (b = 0; b < N_BEAMS; b++) begin : g_beam
      // Object may sit one beam off its taught place
      always_comb begin
        ignore[b] = blank_en && (blank_reg[b]
          || ((b > 0) ? blank_reg[(b > 0) ? b - 1 : b] : 1'b0)
          || ((b < N_BEAMS - 1) ? blank_reg[(b < N_BEAMS - 1) ? b + 1 : b]
              : 1'b0));
        live[b] = beams_blocked[b] && !ignore[b];
      end
    end
  endgenerate

  always_comb begin
    blank_next = teach_pulse ? beams_blocked : blank_reg;
    field_int = |live;
    top_hit = |live[N_BEAMS-1:N_BEAMS-TB];
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  pgs_pkg::pgs_state_e st_reg, st_next;
  pgs_pkg::pgs_cnt_t tmr_reg, tmr_next;
  pgs_pkg::pgs_cnt_t clr_reg, clr_next;
  pgs_pkg::pgs_cnt_t ctl_reg, ctl_next;
  logic req_d_reg, hold_d_reg;
  logic req_rise, req_fall, hold_rise, hold_fall;

  always_comb begin
    req_rise = req && !req_d_reg;
    req_fall = !req && req_d_reg;
    hold_rise = hold && !hold_d_reg;
    hold_fall = !hold && hold_d_reg;
    st_next = st_reg;
    tmr_next = (tmr_reg == '1) ? tmr_reg : tmr_reg + 48'h1;
    clr_next = '0;
    ctl_next = '0;
    case (st_reg)
      pgs_pkg::PGS_IDLE: begin
        tmr_next = '0;
        if (bad_mode) begin
          st_next = pgs_pkg::PGS_IDLE;
        end else if (!pair_mode) begin
          if (req_rise) st_next = pgs_pkg::PGS_ARMED;
        end else if (req_rise && hold_fall) begin
          st_next = pgs_pkg::PGS_ARMED;
        end else if (req_rise || hold_fall) begin
          st_next = pgs_pkg::PGS_PAIR;
        end
      end
      pgs_pkg::PGS_PAIR: begin
        if (req && !hold) begin
          st_next = pgs_pkg::PGS_ARMED;
          tmr_next = '0;
        end else if (tmr_reg >= PAIR_WIN || (!req && hold) || bad_mode) begin
          st_next = pgs_pkg::PGS_IDLE;
        end
      end
      pgs_pkg::PGS_ARMED: begin
        if (bad_mode) begin
          st_next = pgs_pkg::PGS_IDLE;
        end else if (field_int) begin
          st_next = pgs_pkg::PGS_GATING;
          tmr_next = '0;
        end else if (!req || (pair_mode && req_fall && hold_rise)) begin
          st_next = pgs_pkg::PGS_IDLE;
        end else if (tmr_reg >= tol_lim) begin
          st_next = pgs_pkg::PGS_IDLE;
        end
      end
      pgs_pkg::PGS_GATING: begin
        // Counters restart on any break, so gaps are forgiven
        clr_next = field_int ? '0 : clr_reg + 48'h1;
        ctl_next = (field_int || req) ? '0 : ctl_reg + 48'h1;
        if (bad_mode || tmr_reg >= tmo_lim) begin
          st_next = pgs_pkg::PGS_IDLE;
        end else if (clr_reg >= filt_lim) begin
          st_next = pgs_pkg::PGS_IDLE;
        end else if (ctl_reg >= CTL_END) begin
          st_next = pgs_pkg::PGS_IDLE;
        end
      end
      default: st_next = pgs_pkg::PGS_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Safety output and restart interlock

  logic gating;
  logic gate_next;
  logic viol;
  logic lock_reg, lock_next;
  logic safe_reg, safe_next;
  logic [6:0] seg_reg;
  logic fault_reg;
  logic gate_reg;
  logic fi_reg;

  always_comb begin
    gate_next = (st_next == pgs_pkg::PGS_GATING);
    // The break that opens gating is bridged, not a trip
    gating = (st_reg == pgs_pkg::PGS_GATING) || gate_next;
    // Top beams stay guarded in mode 6 even while bridged
    viol = gating ? (m6 && top_hit) : field_int;
    // Trip beats a restart arriving in the same cycle
    if (viol || bad_mode) begin
      lock_next = 1'b1;
    end else if (restart_pulse) begin
      lock_next = 1'b0;
    end else begin
      lock_next = lock_reg;
    end
    safe_next = !lock_next;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= pgs_pkg::PGS_IDLE;
      tmr_reg <= '0;
      clr_reg <= '0;
      ctl_reg <= '0;
      req_d_reg <= 1'b0;
      hold_d_reg <= 1'b0;
      blank_reg <= '0;
      lock_reg <= 1'b1;
      safe_reg <= 1'b0;
      seg_reg <= pgs_pkg::SEG_RST;
      fault_reg <= 1'b0;
      gate_reg <= 1'b0;
      fi_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      clr_reg <= clr_next;
      ctl_reg <= ctl_next;
      req_d_reg <= req;
      hold_d_reg <= hold;
      blank_reg <= blank_next;
      lock_reg <= lock_next;
      safe_reg <= safe_next;
      seg_reg <= seg_next;
      fault_reg <= bad_mode;
      gate_reg <= gate_next;
      fi_reg <= field_int;
    end
  end

  assign safety_on = safe_reg;
  assign mode_fault = fault_reg;
  assign seg_n = seg_reg;
  assign link.process_gating = gate_reg;
  assign link.field_interrupted = fi_reg;
endmodule
`default_nettype wire

// ### design/pgs_link_if.sv
// Interface: link between machine control and gating sequencer
`timescale 1ns/1ps
`default_nettype none
interface pgs_link_if;
  logic gating_request;
  logic timer_hold;
  logic process_gating;
  logic field_interrupted;

  modport device (
    input gating_request,
    input timer_hold,
    output process_gating,
    output field_interrupted
  );

  modport control (
    output gating_request,
    output timer_hold,
    input process_gating,
    input field_interrupted
  );
endinterface
`default_nettype wire

// ### design/pgs_pkg.sv
// Package: constants and types of the gating sequencer and its control end
package pgs_pkg;

  typedef logic [47:0] pgs_cnt_t;

  localparam logic [63:0] CLK_HZ = 64'd200000000;
  localparam logic [63:0] CYC_PER_MS = CLK_HZ / 64'd1000;

  // Times in their own units
  localparam logic [63:0] FILT_M4_MS = 64'd500;
  localparam logic [63:0] FILT_M5_MS = 64'd1000;
  localparam logic [63:0] FILT_M16_MS = 64'd2000;
  localparam logic [63:0] TOL_M4_MS = 64'd2000;
  localparam logic [63:0] TOL_STD_MS = 64'd4000;
  localparam logic [63:0] CTL_END_MS = 64'd100;
  localparam logic [63:0] PAIR_WIN_MS = 64'd500;
  localparam logic [63:0] TMO_MIN = 64'd10;
  localparam logic [63:0] TMO_EXT_H = 64'd100;
  localparam logic [63:0] STRETCH_MS = 64'd200;

  // Derived cycle counts
  localparam pgs_cnt_t FILT_M4_CYC = pgs_cnt_t'(FILT_M4_MS * CYC_PER_MS);
  localparam pgs_cnt_t FILT_M5_CYC = pgs_cnt_t'(FILT_M5_MS * CYC_PER_MS);
  localparam pgs_cnt_t FILT_M16_CYC = pgs_cnt_t'(FILT_M16_MS * CYC_PER_MS);
  localparam pgs_cnt_t TOL_M4_CYC = pgs_cnt_t'(TOL_M4_MS * CYC_PER_MS);
  localparam pgs_cnt_t TOL_STD_CYC = pgs_cnt_t'(TOL_STD_MS * CYC_PER_MS);
  localparam pgs_cnt_t CTL_END_CYC = pgs_cnt_t'(CTL_END_MS * CYC_PER_MS);
  localparam pgs_cnt_t PAIR_WIN_CYC = pgs_cnt_t'(PAIR_WIN_MS * CYC_PER_MS);
  localparam pgs_cnt_t TMO_CYC =
    pgs_cnt_t'(TMO_MIN * 64'd60000 * CYC_PER_MS);
  localparam pgs_cnt_t TMO_EXT_CYC =
    pgs_cnt_t'(TMO_EXT_H * 64'd3600000 * CYC_PER_MS);
  localparam pgs_cnt_t STRETCH_CYC = pgs_cnt_t'(STRETCH_MS * CYC_PER_MS);

  // Wire bridge codes
  localparam logic [2:0] BRIDGE_M1 = 3'h1;
  localparam logic [2:0] BRIDGE_M4 = 3'h2;
  localparam logic [2:0] BRIDGE_M5 = 3'h3;
  localparam logic [2:0] BRIDGE_M6 = 3'h4;

  // Seven-segment patterns, gfedcba, active low
  localparam logic [6:0] SEG_1 = 7'h79;
  localparam logic [6:0] SEG_4 = 7'h19;
  localparam logic [6:0] SEG_5 = 7'h12;
  localparam logic [6:0] SEG_6 = 7'h02;
  localparam logic [6:0] SEG_ERR = 7'h06;
  localparam logic [6:0] SEG_RST = 7'h7F;

  localparam int TOP_BEAMS = 4;

  typedef enum logic [1:0] {
    PGS_IDLE = 2'b00,
    PGS_PAIR = 2'b01,
    PGS_ARMED = 2'b10,
    PGS_GATING = 2'b11
  } pgs_state_e;

  typedef enum logic [0:0] {
    PGC_IDLE = 1'b0,
    PGC_REQ = 1'b1
  } pgs_cstate_e;

endpackage

// ### design/pgs_sync.sv
// Module: three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pgs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pins in, clean levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] lvl_next;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Takes a change only once the second and third stages agree
      always_comb begin
        lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule
`default_nettype wire
